// ### hpc_defs.svh
/*
 Constants of the haptic playback control bank: register offsets, field
 positions, reset values and timing figures.
 Assumes it is included by bare name from the package and the design.
*/
`ifndef HPC_DEFS_SVH
`define HPC_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define HPC_OFS_STATUS 8'h00
`define HPC_OFS_CHIP 8'h01
`define HPC_OFS_CONTROL 8'h02
`define HPC_OFS_SLOT_FIRST 8'h03
`define HPC_OFS_SLOT_SECOND 8'h04
`define HPC_OFS_SLOT_LAST 8'h0A
`define HPC_SLOT_COUNT 8

// ****************************************
// Control field positions
// ****************************************
`define HPC_CTL_SOFT_RST 7
`define HPC_CTL_STANDBY 6
`define HPC_CTL_TIMEOUT_HI 3
`define HPC_CTL_TIMEOUT_LO 2
`define HPC_CTL_FORCE_ON 1
`define HPC_CTL_GO 0

// ****************************************
// Status field positions
// ****************************************
`define HPC_STS_BAD_HEADER 2
`define HPC_STS_QUEUE_EMPTY 1
`define HPC_STS_QUEUE_FULL 0

// ****************************************
// Reset values
// ****************************************
`define HPC_RST_STANDBY 1'b1
`define HPC_RST_TIMEOUT 2'h0
`define HPC_RST_FORCE_ON 1'b0
`define HPC_RST_GO 1'b0
`define HPC_RST_SLOT 8'h00
`define HPC_RST_BAD_HEADER 1'b0

// ****************************************
// Timing
// ****************************************
`define HPC_CLK_MHZ 100
`define HPC_TIMEOUT_STEP_US 5000
`define HPC_QUEUE_BYTES 100

`endif

// ### hpc_pkg.sv
/*
 Types of the haptic playback control bank.
 Assumes hpc_defs.svh is on the include path.
*/
`include "hpc_defs.svh"

package hpc_pkg;

   // ****************************************
   // Register access carrier
   // ****************************************
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } hpc_reg_req_t;

   // Link to the waveform generator
   typedef struct packed {
      logic start;
      logic abort;
      logic [7:0] waveId;
   } hpc_play_cmd_t;

   // Engine states, Gray along idle, fetch, play
   typedef enum logic [1:0] {
      HPC_IDLE = 2'b00,
      HPC_FETCH = 2'b01,
      HPC_PLAY = 2'b11
   } hpc_state_t;

endpackage : hpc_pkg

// ### hpc_playback_control.sv
/*
 Control register, sequence slots and playback engine of the haptic
 front end, plus idle timeout of the boost and amplifier enables.
 Assumes an I2C target outside turns bus bytes into one-cycle register
 strobes, and a waveform generator that pulses done per waveform.
*/
`timescale 1ns/1ps
`include "hpc_defs.svh"

module hpc_playback_control #(
   parameter int STEP_CYCLES = `HPC_TIMEOUT_STEP_US * `HPC_CLK_MHZ
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input hpc_pkg::hpc_reg_req_t regReq,
   output logic [7:0] regRdData,
   input wire logic queueEmpty,
   input wire logic queueFull,
   input wire logic badHeaderEvt,
   input wire logic waveDone,
   output hpc_pkg::hpc_play_cmd_t playCmd,
   output logic standbyMode,
   output logic boostEn,
   output logic ampEn
);
   import hpc_pkg::*;

   // ****************************************
   // Storage
   // ****************************************
   logic standby;
   logic [1:0] timeoutSel;
   logic forceOn;
   logic go;
   logic badHeader;
   logic [7:0] slot [`HPC_SLOT_COUNT];
   hpc_state_t state;
   // Engine position within the slot list
   logic [2:0] slotIdx;
   logic powerOn;
   logic [22:0] idleCnt;

   logic ctlWr;
   logic softRst;
   logic hostGoClr;
   logic seqDone;
   logic [22:0] idleLimit;

   // ****************************************
   // Address decoding
   // ****************************************
   function automatic logic isSlot(input logic [7:0] a);
      isSlot = (a >= `HPC_OFS_SLOT_FIRST) && (a <= `HPC_OFS_SLOT_LAST);
   endfunction : isSlot

   function automatic logic [2:0] slotOf(input logic [7:0] a);
      logic [7:0] d;
      d = a - `HPC_OFS_SLOT_FIRST;
      slotOf = d[2:0];
   endfunction : slotOf

   // ****************************************
   // Write decode
   // ****************************************
   assign ctlWr = regReq.wrEn && (regReq.addr == `HPC_OFS_CONTROL);
   // Soft reset outranks every other field of the same write
   assign softRst = ctlWr && regReq.wrData[`HPC_CTL_SOFT_RST];
   // A clear only counts as a stop while a sequence is running
   assign hostGoClr = ctlWr && !softRst && go
      && !regReq.wrData[`HPC_CTL_GO];

   // Sequence ends on a zero slot or after the last slot's waveform
   always_comb
   begin
      seqDone = 1'b0;
      case (state)
         HPC_FETCH: seqDone = (slot[slotIdx] == 8'h00);
         HPC_PLAY: seqDone = waveDone && (slotIdx == 3'h7);
         default: seqDone = 1'b0;
      endcase
   end

   // ****************************************
   // Control register
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         standby <= `HPC_RST_STANDBY;
         timeoutSel <= `HPC_RST_TIMEOUT;
         forceOn <= `HPC_RST_FORCE_ON;
      end
      else if (softRst)
      begin
         standby <= `HPC_RST_STANDBY;
         timeoutSel <= `HPC_RST_TIMEOUT;
         forceOn <= `HPC_RST_FORCE_ON;
      end
      else if (ctlWr)
      begin
         // Bits 5 and 4 have no storage
         standby <= regReq.wrData[`HPC_CTL_STANDBY];
         timeoutSel <= regReq.wrData[`HPC_CTL_TIMEOUT_HI:
            `HPC_CTL_TIMEOUT_LO];
         forceOn <= regReq.wrData[`HPC_CTL_FORCE_ON];
      end
   end

   // Trigger bit: a host write of one wins over the self-clear
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         go <= `HPC_RST_GO;
      else if (softRst)
         go <= `HPC_RST_GO;
      else if (ctlWr)
         go <= regReq.wrData[`HPC_CTL_GO];
      else if (seqDone)
         go <= 1'b0;
   end

   // ****************************************
   // Sequence slots
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < `HPC_SLOT_COUNT; i++)
            slot[i] <= `HPC_RST_SLOT;
      end
      else if (softRst)
      begin
         for (int i = 0; i < `HPC_SLOT_COUNT; i++)
            slot[i] <= `HPC_RST_SLOT;
      end
      // All eight slots are stored so a full list can play
      else if (regReq.wrEn && isSlot(regReq.addr))
         slot[slotOf(regReq.addr)] <= regReq.wrData;
   end

   // ****************************************
   // Status flags
   // ****************************************
   // Sticky until soft reset; a new event in that cycle still lands
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         badHeader <= `HPC_RST_BAD_HEADER;
      else if (badHeaderEvt)
         badHeader <= 1'b1;
      else if (softRst)
         badHeader <= `HPC_RST_BAD_HEADER;
   end

   // ****************************************
   // Playback engine
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= HPC_IDLE;
         slotIdx <= 3'h0;
      end
      else if (softRst || hostGoClr)
      begin
         state <= HPC_IDLE;
         slotIdx <= 3'h0;
      end
      else
      begin
         case (state)
            HPC_IDLE:
               if (go)
               begin
                  state <= HPC_FETCH;
                  slotIdx <= 3'h0;
               end
            // A zero slot ends here, before any start reaches the generator
            HPC_FETCH:
               if (seqDone)
                  state <= HPC_IDLE;
               else
                  state <= HPC_PLAY;
            HPC_PLAY:
               if (waveDone)
               begin
                  if (seqDone)
                     state <= HPC_IDLE;
                  else
                  begin
                     state <= HPC_FETCH;
                     slotIdx <= slotIdx + 3'h1;
                  end
               end
            default:
               state <= HPC_IDLE;
         endcase
      end
   end

   // Generator commands are registered one-cycle pulses
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         playCmd <= '0;
      else
      begin
         playCmd.start <= (state == HPC_FETCH) && !seqDone
            && !softRst && !hostGoClr;
         playCmd.abort <= (softRst || hostGoClr)
            && (state != HPC_IDLE);
         // Id stays put after start, so the generator may latch it late
         if (state == HPC_FETCH)
            playCmd.waveId <= slot[slotIdx];
      end
   end

   // ****************************************
   // Power sequencing
   // ****************************************
   // Limit is (code + 1) steps of 5 ms
   assign idleLimit = 23'((32'(timeoutSel) + 32'd1) * STEP_CYCLES);

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         powerOn <= 1'b0;
         idleCnt <= 23'h0;
      end
      else if (softRst || standby)
      begin
         powerOn <= 1'b0;
         idleCnt <= 23'h0;
      end
      else if (!queueEmpty || state != HPC_IDLE)
      begin
         powerOn <= 1'b1;
         idleCnt <= 23'h0;
      end
      else if (powerOn)
      begin
         // Counting only while powered keeps the counter quiet in idle
         if (idleCnt >= idleLimit - 23'h1)
         begin
            powerOn <= 1'b0;
            idleCnt <= 23'h0;
         end
         else
            idleCnt <= idleCnt + 23'h1;
      end
   end

   // Force outranks standby: a forced part never saves power
   assign boostEn = forceOn | powerOn;
   assign ampEn = forceOn | powerOn;
   assign standbyMode = standby;

   // ****************************************
   // Read path
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         regRdData <= 8'h00;
      else if (regReq.rdEn)
      begin
         // Queue flags are live; only the bad-header flag is sticky
         if (regReq.addr == `HPC_OFS_STATUS)
            regRdData <= {5'h00, badHeader, queueEmpty, queueFull};
         else if (regReq.addr == `HPC_OFS_CONTROL)
            regRdData <= {1'b0, standby, 2'b00, timeoutSel,
               forceOn, go};
         else if (isSlot(regReq.addr))
            regRdData <= slot[slotOf(regReq.addr)];
         else
            regRdData <= 8'h00;
      end
   end

endmodule : hpc_playback_control

// ### hpc_playback_control_chk.sv
/* Port checker of the playback bank.
 Bound into hpc_playback_control after the module. */
`timescale 1ns/1ps
module hpc_playback_control_chk #(
   parameter int STEP_CYCLES = 500000
) (
   input logic clk_sys,
   input logic rst_b,
   input hpc_pkg::hpc_reg_req_t regReq,
   input logic [7:0] regRdData,
   input logic queueEmpty,
   input hpc_pkg::hpc_play_cmd_t playCmd,
   input logic standbyMode,
   input logic boostEn,
   input logic ampEn
);
   import hpc_pkg::*;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   sequence s_ctl_wr;
      regReq.wrEn && regReq.addr == 8'h02;
   endsequence
   sequence s_rd(a);
      regReq.rdEn && regReq.addr == a;
   endsequence
   a_soft_rst: assert property (s_ctl_wr ##0 regReq.wrData[7]
      |=> standbyMode && !boostEn) else $error("soft reset missed");
   a_force_hold: assert property (s_ctl_wr ##0
      (regReq.wrData & 8'h82) == 8'h02 |=> boostEn [*2])
      else $error("force did not hold enables");
   a_amp_match: assert property (ampEn == boostEn)
      else $error("enables differ");
   a_start_pulse: assert property (playCmd.start |=> !playCmd.start)
      else $error("start longer than one cycle");
   a_zero_skip: assert property (playCmd.start |->
      playCmd.waveId != 8'h00) else $error("zero id played");
   a_ctl_rsv: assert property (s_rd(8'h02) |=>
      regRdData[7] == 1'b0 && regRdData[5:4] == 2'b00)
      else $error("reserved bits not zero");
   a_empty_flag: assert property (s_rd(8'h00) |=>
      regRdData[1] == $past(queueEmpty)) else $error("empty flag wrong");
   a_abort_pulse: assert property (playCmd.abort |=> !playCmd.abort)
      else $error("abort longer than one cycle");
   a_abort_excl: assert property (playCmd.abort |-> !playCmd.start)
      else $error("abort with start");
   a_id_hold: assert property (playCmd.start |=>
      $stable(playCmd.waveId)) else $error("id changed after start");
endmodule : hpc_playback_control_chk

bind hpc_playback_control hpc_playback_control_chk #(
   .STEP_CYCLES(STEP_CYCLES)
) u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .regReq(regReq),
   .regRdData(regRdData), .queueEmpty(queueEmpty), .playCmd(playCmd),
   .standbyMode(standbyMode), .boostEn(boostEn), .ampEn(ampEn));

// ### hpc_wave_gen.sv
/* Waveform generator model: answers each start with one done pulse, unless an abort drops it first.
 Assumes registered start and abort pulses from the bank. */
`timescale 1ns/1ps
module hpc_wave_gen #(
   parameter int PLAY_CYCLES = 6
) (
   input logic clk_sys,
   input logic rst_b,
   input hpc_pkg::hpc_play_cmd_t playCmd,
   output logic waveDone,
   output logic [7:0] lastId,
   output int starts
);
   int left;
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         left <= 0;
         waveDone <= 1'b0;
         lastId <= 8'h00;
         starts <= 0;
      end
      else
      begin
         waveDone <= left == 1;
         left <= left > 0 ? left - 1 : 0;
         // Abort drops the wave so no late done can restart the list
         if (playCmd.abort)
            left <= 0;
         if (playCmd.start)
         begin
            starts <= starts + 1;
            lastId <= playCmd.waveId;
            left <= PLAY_CYCLES;
         end
      end
   end
endmodule : hpc_wave_gen

// ### hpc_playback_control_tb.sv
/* Bench of the playback bank with the generator model.
 Assumes STEP_CYCLES of 10 for the idle timeout. */
`timescale 1ns/1ps
module hpc_playback_control_tb;
   import hpc_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   hpc_reg_req_t regReq = '0;
   logic queueEmpty = 1'b1;
   logic queueFull = 1'b0;
   logic badHeaderEvt = 1'b0;
   logic waveDone, standbyMode, boostEn, ampEn;
   hpc_play_cmd_t playCmd;
   logic [7:0] regRdData, lastId, got;
   int starts, n, error_cnt = 0, checks_done = 0;
   // Address, write byte, expected read back
   logic [23:0] rows [8] = '{24'h024C4C, 24'h023C0C, 24'h035A5A,
      24'h04A5A5, 24'h0A3333, 24'h0B7700, 24'h01FF00, 24'h00FF02};
   hpc_playback_control #(.STEP_CYCLES(10)) u_dut (.clk_sys(clk_sys),
      .rst_b(rst_b), .regReq(regReq), .regRdData(regRdData),
      .queueEmpty(queueEmpty), .queueFull(queueFull),
      .badHeaderEvt(badHeaderEvt), .waveDone(waveDone), .playCmd(playCmd),
      .standbyMode(standbyMode), .boostEn(boostEn), .ampEn(ampEn));
   hpc_wave_gen u_gen (.clk_sys(clk_sys), .rst_b(rst_b), .playCmd(playCmd),
      .waveDone(waveDone), .lastId(lastId), .starts(starts));
   initial forever #5 clk_sys = ~clk_sys;
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   // Gap cycle between requests keeps each strobe a single pulse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1 regReq = '{1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      #1 regReq = '0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      #1 regReq = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      #1 regReq = '0;
      got = regRdData;
   endtask : rd
   task automatic wait_go();
      n = 0;
      do
      begin
         rd(8'h02);
         n++;
      end
      while (got[0] === 1'b1 && n < 100);
   endtask : wait_go
   initial
   begin
      #100000;
      error_cnt++;
      wrap_up();
   end
   initial
   begin
      repeat (5) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      rd(8'h02);
      chk(got, 8'h40);
      foreach (rows[i])
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         chk(got, rows[i][7:0]);
      end
      $display("table done");
      wr(8'h03, 8'h05);
      wr(8'h04, 8'h09);
      wr(8'h02, 8'h01);
      rd(8'h02);
      chk(got, 8'h01);
      wait_go();
      chk(8'(starts), 8'h02);
      chk(lastId, 8'h09);
      for (int k = 0; k < 8; k++)
         wr(8'(8'h03 + k), 8'(k + 1));
      wr(8'h02, 8'h01);
      wait_go();
      chk(8'(starts), 8'h0A);
      chk(lastId, 8'h08);
      wr(8'h02, 8'h01);
      repeat (3) @(posedge clk_sys);
      wr(8'h02, 8'h00);
      repeat (30) @(posedge clk_sys);
      rd(8'h02);
      chk(got, 8'h00);
      chk(8'(starts), 8'h0B);
      $display("playback done");
      wr(8'h02, 8'h04);
      queueEmpty = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 chk({7'h00, boostEn}, 8'h01);
      chk({7'h00, standbyMode}, 8'h00);
      queueEmpty = 1'b1;
      n = 0;
      while (boostEn === 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         #1 n++;
      end
      // Code 1 is two steps of ten cycles in this bench
      chk(8'(n), 8'h14);
      chk({7'h00, ampEn}, 8'h00);
      wr(8'h02, 8'h42);
      repeat (30) @(posedge clk_sys);
      #1 chk({7'h00, boostEn}, 8'h01);
      $display("power done");
      badHeaderEvt = 1'b1;
      @(posedge clk_sys);
      #1 badHeaderEvt = 1'b0;
      queueFull = 1'b1;
      rd(8'h00);
      chk(got, 8'h07);
      queueFull = 1'b0;
      wr(8'h02, 8'h01);
      repeat (3) @(posedge clk_sys);
      wr(8'h02, 8'hBF);
      chk({7'h00, boostEn}, 8'h00);
      rd(8'h02);
      chk(got, 8'h40);
      rd(8'h03);
      chk(got, 8'h00);
      rd(8'h00);
      chk(got, 8'h02);
      chk({7'h00, standbyMode}, 8'h01);
      chk(8'(starts), 8'h0C);
      $display("soft reset done");
      wr(8'h02, 8'h0E);
      rst_b = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      rd(8'h02);
      chk(got, 8'h40);
      chk({7'h00, ampEn}, 8'h00);
      $display("hard reset done");
      wrap_up();
   end
endmodule : hpc_playback_control_tb
